// file: amp_guard_consts.vh
/*
 * Constants of the class-D fault and protection supervisor: register
 * offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef AMP_GUARD_CONSTS_VH
`define AMP_GUARD_CONSTS_VH

// ************************************************
// Register byte offsets
// ************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CHAN 8'h08

// ************************************************
// Control fields
// ************************************************
`define CTRL_MODE_LSB 0
`define CTRL_ALT_MOD_BIT 2
`define CTRL_RESET_VAL 2'h1
`define MODE_SINGLE 2'h0
`define MODE_BRIDGED 2'h1
`define MODE_MIXED 2'h2
`define MODE_PARALLEL 2'h3

// ************************************************
// Status fields
// ************************************************
`define ST_UNDERVOLT_BIT 0
`define ST_POR_BIT 1
`define ST_THERMAL_BIT 2
`define ST_OVERLOAD_BIT 3
`define ST_WARN_BIT 4
`define ST_SAT_BIT 5
`define ST_RESET_IN_BIT 6
`define ST_CFG_REJECT_BIT 7
`define ST_SHUTDOWN_PIN_BIT 8
`define ST_WARN_PIN_BIT 9
`define ST_SAT_PIN_BIT 10

// ************************************************
// AXI responses
// ************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ************************************************
// Timing
// ************************************************
`define CLK_FREQ_MHZ 50
`define OVERLOAD_TIME_US 2600
`define OVERLOAD_CYCLES (`OVERLOAD_TIME_US * `CLK_FREQ_MHZ)
`define STUCK_TIME_US 20
`define STUCK_CYCLES (`STUCK_TIME_US * `CLK_FREQ_MHZ)

`endif

// file: bridge_channel_guard.v
/*
 * One half-bridge channel: drive of its high and low side, current
 * limiting, overload latch, bootstrap guard and missing PWM detection.
 * Assumes synchronised inputs on core_clk and a parent that permits run.
 */
`timescale 1ns/100ps
`default_nettype none

module bridge_channel_guard #(
   parameter TRIP_CYCLES = 130000,
   parameter STUCK_CYCLES = 1000,
   parameter CNT_W = 18
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   input wire ce,
   // Conditions
   input wire pwm,
   input wire oc,
   input wire boot_low,
   input wire oc_latch_mode,
   input wire clear,
   input wire run,
   // Results
   output reg hs_on_q,
   output reg ls_on_q,
   output reg stuck_q,
   output reg overload_q,
   output reg limiting_q
);

   reg pwm_prev_q;
   reg [CNT_W-1:0] oc_cnt_q;
   reg [CNT_W-1:0] idle_cnt_q;
   wire off;
   wire flip;

   assign off = ~run | overload_q | stuck_q;
   assign flip = oc & ~oc_latch_mode;

   // ************************************************
   // Overload latch and missing PWM watch
   // ************************************************
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_prev_q <= 1'b0;
         oc_cnt_q <= {CNT_W{1'b0}};
         idle_cnt_q <= {CNT_W{1'b0}};
         stuck_q <= 1'b0;
         overload_q <= 1'b0;
         limiting_q <= 1'b0;
      end else if (ce) begin
         pwm_prev_q <= pwm;
         limiting_q <= flip & run;
         // Latch until cleared, the set holds past a self-clearing end
         if (clear)
            overload_q <= 1'b0;
         else if (run & oc & oc_latch_mode)
            overload_q <= 1'b1;
         else if (run & flip & (oc_cnt_q >= TRIP_CYCLES[CNT_W-1:0] - 1'b1))
            overload_q <= 1'b1;
         if (flip & run & (oc_cnt_q != {CNT_W{1'b1}}))
            oc_cnt_q <= oc_cnt_q + 1'b1;
         else if (~flip)
            oc_cnt_q <= {CNT_W{1'b0}};
         // Stuck input resumes on its own once edges return
         if (pwm != pwm_prev_q) begin
            idle_cnt_q <= {CNT_W{1'b0}};
            stuck_q <= 1'b0;
         end else if (idle_cnt_q >= STUCK_CYCLES[CNT_W-1:0] - 1'b1) begin
            stuck_q <= 1'b1;
         end else begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
         end
      end
   end

   // ************************************************
   // Bridge drive
   // ************************************************
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hs_on_q <= 1'b0;
         ls_on_q <= 1'b0;
      end else if (ce) begin
         if (off) begin
            hs_on_q <= 1'b0;
            ls_on_q <= 1'b0;
         end else begin
            // Inverted path; limiting swaps the high and low side drive while oc is seen with oc_latch_mode low
            hs_on_q <= (flip ? pwm : ~pwm) & ~boot_low;
            ls_on_q <= flip ? ~pwm : pwm;
         end
      end
   end

endmodule // bridge_channel_guard

`default_nettype wire

// file: amp_fault_protection_supervisor.v
/*
 * Fault and protection supervisor of a four half-bridge class-D stage,
 * with an AXI4-Lite register slave, status pins and bridge drive.
 * Assumes a single 50 MHz clock; every pin input is asynchronous.
 */
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "amp_guard_consts.vh"

module amp_fault_protection_supervisor #(
   parameter NCH = 4,
   parameter TRIP_CYCLES = `OVERLOAD_CYCLES,
   parameter STUCK_CYCLES = `STUCK_CYCLES,
   parameter CNT_W = 18
) (
   // Clock, reset, enable
   input wire core_clk,
   input wire nrst,
   input wire ce,
   // AXI4-Lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Device reset pin and supply monitors
   input wire amp_reset_n,
   input wire [3:0] supply_low_guard,
   input wire logic_supply_low,
   // Thermal sensing
   input wire temp_warn_hot,
   input wire temp_trip_hot,
   // Per channel sensing
   input wire [NCH-1:0] pwm_in,
   input wire [NCH-1:0] oc_detect,
   input wire [NCH-1:0] bootstrap_supply_low,
   input wire [NCH-1:0] loop_saturated,
   input wire oc_latch_strap,
   // Bridge drive
   output wire [NCH-1:0] hs_on,
   output wire [NCH-1:0] ls_on,
   output reg [NCH-1:0] pulldown_en,
   // Open-drain status pins
   input wire shutdown_flag_n_i,
   output reg shutdown_flag_n_o,
   output reg shutdown_flag_n_oe,
   input wire overtemp_warning_n_i,
   output reg overtemp_warning_n_o,
   output reg overtemp_warning_n_oe,
   input wire saturation_flag_n_i,
   output reg saturation_flag_n_o,
   output reg saturation_flag_n_oe
);

   localparam SW = 4 * NCH + 12;

   // ************************************************
   // Input synchronisers
   // ************************************************
   wire [SW-1:0] async_in;
   reg [SW-1:0] sync1_q;
   reg [SW-1:0] sync2_q;

   assign async_in = {saturation_flag_n_i, overtemp_warning_n_i, shutdown_flag_n_i,
                      oc_latch_strap, loop_saturated, bootstrap_supply_low, oc_detect,
                      pwm_in, temp_trip_hot, temp_warn_hot, logic_supply_low,
                      supply_low_guard, amp_reset_n};

   // Two stages on every pin input
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= {SW{1'b0}};
         sync2_q <= {SW{1'b0}};
      end else if (ce) begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   wire rst_pin;
   wire supply_low;
   wire por_low;
   wire warn_hot;
   wire trip_hot;
   wire [NCH-1:0] pwm_s;
   wire [NCH-1:0] oc_s;
   wire [NCH-1:0] boot_s;
   wire [NCH-1:0] sat_s;
   wire strap_s;
   wire [2:0] pin_lvl;

   assign rst_pin = sync2_q[0];
   assign supply_low = |sync2_q[4:1];
   assign por_low = sync2_q[5];
   assign warn_hot = sync2_q[6];
   assign trip_hot = sync2_q[7];
   assign pwm_s = sync2_q[8 +: NCH];
   assign oc_s = sync2_q[8 + NCH +: NCH];
   assign boot_s = sync2_q[8 + 2 * NCH +: NCH];
   assign sat_s = sync2_q[8 + 3 * NCH +: NCH];
   assign strap_s = sync2_q[8 + 4 * NCH];
   assign pin_lvl = sync2_q[SW-1 -: 3];

   // ************************************************
   // Control register and global fault state
   // ************************************************
   reg [1:0] out_mode_q;
   reg alt_mod_q;
   reg cfg_reject_q;
   reg thermal_trip_q;
   reg run_q;
   reg rst_pin_q;
   wire [NCH-1:0] stuck;
   wire [NCH-1:0] overload;
   wire [NCH-1:0] limiting;
   wire all_stuck;
   wire any_overload;
   wire self_clear_fault;
   wire latched_fault;
   wire chan_clear;
   wire run;

   assign all_stuck = &stuck;
   assign any_overload = |overload;
   // Self-clearing supply faults kept apart from latched ones
   assign self_clear_fault = supply_low | por_low;
   assign latched_fault = thermal_trip_q | any_overload;
   assign chan_clear = ~rst_pin | por_low;
   assign run = run_q & ~self_clear_fault & ~thermal_trip_q & ~all_stuck;

   // Thermal latch and run state from reset pin edges
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         thermal_trip_q <= 1'b0;
         run_q <= 1'b0;
         rst_pin_q <= 1'b0;
      end else if (ce) begin
         rst_pin_q <= rst_pin;
         if (~rst_pin)
            thermal_trip_q <= 1'b0;
         else if (trip_hot)
            thermal_trip_q <= 1'b1;
         if (~rst_pin)
            run_q <= 1'b0;
         else if (~rst_pin_q)
            run_q <= 1'b1;
      end
   end

   // ************************************************
   // Per channel guards
   // ************************************************
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : chan
         bridge_channel_guard #(
            .TRIP_CYCLES(TRIP_CYCLES),
            .STUCK_CYCLES(STUCK_CYCLES),
            .CNT_W(CNT_W)
         ) u_guard (
            .core_clk(core_clk),
            .nrst(nrst),
            .ce(ce),
            .pwm(pwm_s[g]),
            .oc(oc_s[g]),
            .boot_low(boot_s[g]),
            .oc_latch_mode(strap_s),
            .clear(chan_clear),
            .run(run),
            .hs_on_q(hs_on[g]),
            .ls_on_q(ls_on[g]),
            .stuck_q(stuck[g]),
            .overload_q(overload[g]),
            .limiting_q(limiting[g])
         );
      end
   endgenerate

   // ************************************************
   // Status pins and pull-down
   // ************************************************
   wire flag_fault;
   wire flag_sat;

   assign flag_fault = rst_pin & (self_clear_fault | latched_fault);
   assign flag_sat = run & (|sat_s);

   // Open-drain drive: enable pulls low, released pin reads high
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         shutdown_flag_n_o <= 1'b1;
         shutdown_flag_n_oe <= 1'b0;
         overtemp_warning_n_o <= 1'b1;
         overtemp_warning_n_oe <= 1'b0;
         saturation_flag_n_o <= 1'b1;
         saturation_flag_n_oe <= 1'b0;
         pulldown_en <= {NCH{1'b0}};
      end else if (ce) begin
         shutdown_flag_n_o <= ~flag_fault;
         shutdown_flag_n_oe <= flag_fault;
         overtemp_warning_n_o <= ~warn_hot;
         overtemp_warning_n_oe <= warn_hot;
         saturation_flag_n_o <= ~flag_sat;
         saturation_flag_n_oe <= flag_sat;
         // Weak pull-down charges bootstrap caps while held in reset, in every mode but MODE_SINGLE
         pulldown_en <= {NCH{~rst_pin & (out_mode_q != `MODE_SINGLE)}};
      end
   end

   // ************************************************
   // AXI4-Lite write channel
   // ************************************************
   reg aw_have_q;
   reg w_have_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire do_write;
   wire [1:0] new_mode;
   wire new_alt;
   wire cfg_ok;

   assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign new_mode = w_data_q[`CTRL_MODE_LSB +: 2];
   assign new_alt = w_data_q[`CTRL_ALT_MOD_BIT];
   assign cfg_ok = ~new_alt | (new_mode == `MODE_BRIDGED) |
                   (new_mode == `MODE_PARALLEL);

   // Address and data taken in either order, answer after both
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         out_mode_q <= `CTRL_RESET_VAL;
         alt_mod_q <= 1'b0;
         cfg_reject_q <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (aw_addr_q[7:2])
               (`REG_CTRL >> 2): begin
                  if (w_strb_q[0] & cfg_ok) begin
                     out_mode_q <= new_mode;
                     alt_mod_q <= new_alt;
                  end
               end
               (`REG_STATUS >> 2): begin
               end
               (`REG_CHAN >> 2): begin
               end
               default: begin
                  s_axi_bresp <= `RESP_SLVERR;
               end
            endcase
         end
         // Rejected mode sticks; a new rejection beats the clear
         if (do_write & (aw_addr_q[7:2] == (`REG_CTRL >> 2)) & w_strb_q[0] & ~cfg_ok)
            cfg_reject_q <= 1'b1;
         else if (do_write & (aw_addr_q[7:2] == (`REG_STATUS >> 2)) & w_strb_q[0] &
                  w_data_q[`ST_CFG_REJECT_BIT])
            cfg_reject_q <= 1'b0;
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ************************************************
   // AXI4-Lite read channel
   // ************************************************
   reg [31:0] rd_mux;

   // Register read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr[7:2])
         (`REG_CTRL >> 2): begin
            rd_mux[`CTRL_MODE_LSB +: 2] = out_mode_q;
            rd_mux[`CTRL_ALT_MOD_BIT] = alt_mod_q;
         end
         (`REG_STATUS >> 2): begin
            rd_mux[`ST_UNDERVOLT_BIT] = supply_low;
            rd_mux[`ST_POR_BIT] = por_low;
            rd_mux[`ST_THERMAL_BIT] = thermal_trip_q;
            rd_mux[`ST_OVERLOAD_BIT] = any_overload;
            rd_mux[`ST_WARN_BIT] = warn_hot;
            rd_mux[`ST_SAT_BIT] = |sat_s;
            rd_mux[`ST_RESET_IN_BIT] = rst_pin;
            rd_mux[`ST_CFG_REJECT_BIT] = cfg_reject_q;
            rd_mux[`ST_SHUTDOWN_PIN_BIT +: 3] = pin_lvl;
         end
         (`REG_CHAN >> 2): begin
            rd_mux[4 * NCH - 1:0] = {boot_s, limiting, stuck, overload};
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // One-cycle read answer held until taken
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            if (s_axi_araddr[7:2] > (`REG_CHAN >> 2))
               s_axi_rresp <= `RESP_SLVERR;
            else
               s_axi_rresp <= `RESP_OKAY;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // amp_fault_protection_supervisor

`default_nettype wire

// file: amp_partner.sv
/* Partner model: PWM modulator and host GPIO that own the reset pin.
   Assumes open-drain pins resolved by the bench, pull-up when released. */
`timescale 1ns/100ps
`default_nettype none
module amp_partner #(
   parameter HOLD = 40
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Host requests and watched pins
   input wire logic want_run,
   input wire logic [3:0] stop,
   input wire logic flag_pin,
   input wire logic warn_pin,
   // Driven pins
   output var logic amp_reset_n,
   output var logic [3:0] pwm_in,
   output var logic [2:0] phase
);
   logic flag_q;
   int wait_q;
   // PWM frames, fault hold-off and reset pin
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase <= 3'h0;
         pwm_in <= 4'h5;
         flag_q <= 1'b1;
         wait_q <= HOLD;
         amp_reset_n <= 1'b0;
      end else begin
         phase <= phase + 3'h1;
         if (phase == 3'h7) pwm_in <= pwm_in ^ ~stop; // Stopped lanes hold level
         flag_q <= flag_pin;
         if (flag_q && !flag_pin) wait_q <= 0;
         else if (wait_q < HOLD) wait_q <= wait_q + 1;
         if (!want_run) amp_reset_n <= 1'b0;
         else if (wait_q >= HOLD && warn_pin) amp_reset_n <= 1'b1;
      end
   end
endmodule // amp_partner
`default_nettype wire

// file: amp_guard_chk.sv
/* Checker of the supervisor's pins and bridge drive.
   Assumes ce held high and bind onto the supervisor top. */
`timescale 1ns/100ps
`default_nettype none
module amp_guard_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Watched inputs
   input wire logic amp_reset_n,
   input wire logic [3:0] supply_low_guard,
   input wire logic logic_supply_low,
   input wire logic temp_warn_hot,
   input wire logic temp_trip_hot,
   input wire logic [3:0] oc_detect,
   input wire logic [3:0] bootstrap_supply_low,
   input wire logic oc_latch_strap,
   // Watched outputs
   input wire logic [3:0] hs_on,
   input wire logic [3:0] ls_on,
   input wire logic [3:0] pulldown_en,
   input wire logic shutdown_flag_n_o,
   input wire logic shutdown_flag_n_oe,
   input wire logic overtemp_warning_n_o,
   input wire logic overtemp_warning_n_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Sync delays give each rule a few cycles to act
   a_reset_flag_off: assert property (!amp_reset_n [*5] |-> !shutdown_flag_n_oe)
      else $error("shutdown flag pulled while reset pin low");
   a_reset_hiz: assert property (!amp_reset_n [*5] |-> hs_on == 4'h0 && ls_on == 4'h0)
      else $error("bridge driven while reset pin low");
   a_pulldown_run: assert property (amp_reset_n [*5] |-> pulldown_en == 4'h0)
      else $error("pull-down on while running");
   a_supply_off: assert property ((amp_reset_n && supply_low_guard != 4'h0) [*7]
      |-> hs_on == 4'h0 && ls_on == 4'h0 && shutdown_flag_n_oe)
      else $error("supply low not shut down");
   a_por_off: assert property (logic_supply_low [*5] |-> hs_on == 4'h0 && ls_on == 4'h0)
      else $error("bridge driven during power-on clear");
   a_warn_set: assert property (temp_warn_hot [*5] |-> overtemp_warning_n_oe)
      else $error("warning pin not pulled");
   a_warn_clear: assert property (!temp_warn_hot [*5] |-> !overtemp_warning_n_oe)
      else $error("warning pin stuck low");
   a_trip_latched: assert property ((amp_reset_n && temp_trip_hot) [*6] ##1 amp_reset_n [*4]
      |-> shutdown_flag_n_oe)
      else $error("thermal trip not latched");
   a_oc_latched: assert property ((amp_reset_n && oc_latch_strap && oc_detect[0]) [*8]
      |-> shutdown_flag_n_oe)
      else $error("latched overcurrent not flagged");
   a_boot_high_off: assert property (bootstrap_supply_low[2] [*5] |-> !hs_on[2])
      else $error("high side on with bootstrap low");
   a_pin_polarity: assert property (!(shutdown_flag_n_oe && shutdown_flag_n_o)
      && !(overtemp_warning_n_oe && overtemp_warning_n_o))
      else $error("open-drain pin drives high");
endmodule // amp_guard_chk
bind amp_fault_protection_supervisor amp_guard_chk i_chk (.*);
`default_nettype wire

// file: amp_fault_protection_supervisor_tb.sv
/* Self-checking bench of the class-D fault supervisor.
   Assumes the partner model owns the reset pin and the PWM inputs. */
`timescale 1ns/100ps
`default_nettype none
`include "amp_guard_consts.vh"
module amp_fault_protection_supervisor_tb;
   // ************************************************
   // Signals
   // ************************************************
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
   note_t rq[$];
   note_t bq[$];
   logic core_clk, nrst, ce, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb, supply, oc, boot, sat, stop;
   logic por, warn, trip, strap, want_run, ok;
   logic [2:0] v, cur;
   wire logic awready, wready, bvalid, arready, rvalid, amp_reset_n;
   wire logic sd_o, sd_oe, ow_o, ow_oe, sf_o, sf_oe;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [3:0] pwm_in, hs_on, ls_on, pulldown_en;
   wire logic [2:0] phase;
   // Pull-ups on the open-drain pins
   wire logic sd_pin = sd_oe ? sd_o : 1'b1;
   wire logic ow_pin = ow_oe ? ow_o : 1'b1;
   wire logic sf_pin = sf_oe ? sf_o : 1'b1;
   int n_errors, samples_checked, i;
   integer seed = 32'hae67_fbcc;
   always #10 core_clk = ~core_clk;
   amp_fault_protection_supervisor #(.NCH(4), .TRIP_CYCLES(20), .STUCK_CYCLES(20), .CNT_W(18)) i_dut (
      .core_clk(core_clk), .nrst(nrst), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .amp_reset_n(amp_reset_n), .supply_low_guard(supply), .logic_supply_low(por),
      .temp_warn_hot(warn), .temp_trip_hot(trip), .pwm_in(pwm_in), .oc_detect(oc),
      .bootstrap_supply_low(boot), .loop_saturated(sat), .oc_latch_strap(strap),
      .hs_on(hs_on), .ls_on(ls_on), .pulldown_en(pulldown_en),
      .shutdown_flag_n_i(sd_pin), .shutdown_flag_n_o(sd_o), .shutdown_flag_n_oe(sd_oe),
      .overtemp_warning_n_i(ow_pin), .overtemp_warning_n_o(ow_o), .overtemp_warning_n_oe(ow_oe),
      .saturation_flag_n_i(sf_pin), .saturation_flag_n_o(sf_o), .saturation_flag_n_oe(sf_oe));
   amp_partner #(.HOLD(40)) i_partner (.core_clk(core_clk), .nrst(nrst), .want_run(want_run),
      .stop(stop), .flag_pin(sd_pin), .warn_pin(ow_pin), .amp_reset_n(amp_reset_n),
      .pwm_in(pwm_in), .phase(phase));
   // ************************************************
   // Tasks
   // ************************************************
   task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
      begin
         samples_checked++;
         if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
         end
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // One write; unmapped offsets answer with an error
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw;
      begin
         ha = 1'b0;
         hw = 1'b0;
         bq.push_back('{32'h0, 32'h0, (a > `REG_CHAN) ? `RESP_SLVERR : `RESP_OKAY});
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (!(ha && hw)) begin
            @(posedge core_clk);
            if (awready && !ha) awvalid <= 1'b0;
            if (wready && !hw) wvalid <= 1'b0;
            ha = ha || awready;
            hw = hw || wready;
         end
         do @(posedge core_clk); while (!bvalid);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      begin
         rq.push_back('{e, m, (a > `REG_CHAN) ? `RESP_SLVERR : `RESP_OKAY});
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge core_clk); while (!arready);
         arvalid <= 1'b0;
         do @(posedge core_clk); while (!rvalid);
      end
   endtask
   // Drive compared in a settled part of the PWM frame
   task automatic drive_ok(input logic [3:0] m);
      begin
         while (phase !== 3'h6) @(posedge core_clk);
         check_word("hs_on", {28'h0, ~pwm_in & m}, {28'h0, hs_on & m});
         check_word("ls_on", {28'h0, pwm_in & m}, {28'h0, ls_on & m});
      end
   endtask
   task test_done;
      begin
         $display("checks %0d errors %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // Oldest note compared against each bus answer
   always @(posedge core_clk) begin
      note_t n;
      if (rvalid && rready) begin
         n = rq.pop_front();
         check_word("rdata", n.d & n.m, rdata & n.m);
         check_word("rresp", {30'h0, n.r}, {30'h0, rresp});
      end
      if (bvalid && bready) begin
         n = bq.pop_front();
         check_word("bresp", {30'h0, n.r}, {30'h0, bresp});
      end
   end
   // Watchdog
   initial begin
      #400000;
      n_errors++;
      test_done;
   end
   // ************************************************
   // Scenarios
   // ************************************************
   initial begin
      {core_clk, nrst, awvalid, wvalid, bready, arvalid, rready, want_run} = 8'h0;
      {por, warn, trip, strap, awaddr, araddr, wdata} = 52'h0;
      {supply, oc, boot, sat, stop} = 20'h0;
      ce = 1'b1;
      wstrb = 4'hf;
      n_errors = 0;
      samples_checked = 0;
      w(12);
      nrst <= 1'b1;
      w(4);
      check_word("pulldown", 32'hf, {28'h0, pulldown_en});
      rd(`REG_CTRL, 32'h1, 32'h7);
      rd(8'h0c, 32'h0, 32'hffff_ffff);
      wr(8'h0c, 32'h0);
      wr(`REG_CTRL, 32'h0);
      w(6);
      check_word("pulldown", 32'h0, {28'h0, pulldown_en});
      wr(`REG_CTRL, 32'h1);
      cur = 3'h1;
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         ok = !v[2] || v[1:0] == `MODE_BRIDGED || v[1:0] == `MODE_PARALLEL;
         if (ok) cur = v;
         wr(`REG_CTRL, {29'h0, v});
         rd(`REG_CTRL, {29'h0, cur}, 32'h7);
         rd(`REG_STATUS, {24'h0, !ok, 7'h0}, 32'h80);
         wr(`REG_STATUS, 32'h80);
      end
      wr(`REG_CTRL, 32'h1);
      want_run <= 1'b1;
      w(12);
      drive_ok(4'hf);
      rd(`REG_STATUS, 32'h340, 32'h35f);
      warn <= 1'b1;
      w(8);
      rd(`REG_STATUS, 32'h150, 32'h35f);
      drive_ok(4'hf);
      warn <= 1'b0;
      sat <= 4'h1;
      w(8);
      rd(`REG_STATUS, 32'h320, 32'h735);
      sat <= 4'h0;
      supply <= 4'h1 << ($random(seed) & 3);
      w(8);
      rd(`REG_STATUS, 32'h241, 32'h35f);
      supply <= 4'h0;
      w(12);
      rd(`REG_STATUS, 32'h340, 32'h35f);
      stop <= 4'hf;
      w(40);
      rd(`REG_CHAN, 32'hf0, 32'hff);
      rd(`REG_STATUS, 32'h340, 32'h35f);
      stop <= 4'h0;
      w(40);
      rd(`REG_CHAN, 32'h0, 32'hf0);
      boot <= 4'h4;
      w(8);
      rd(`REG_CHAN, 32'h4000, 32'hf00f);
      rd(`REG_STATUS, 32'h340, 32'h35f);
      boot <= 4'h0;
      oc <= 4'h2;
      w(6);
      rd(`REG_CHAN, 32'h200, 32'hf0f);
      rd(`REG_STATUS, 32'h340, 32'h35f);
      w(30);
      rd(`REG_CHAN, 32'h2, 32'hf);
      oc <= 4'h0;
      w(8);
      rd(`REG_STATUS, 32'h248, 32'h35f);
      por <= 1'b1;
      w(8);
      por <= 1'b0;
      w(12);
      rd(`REG_CHAN, 32'h0, 32'hf);
      trip <= 1'b1;
      warn <= 1'b1;
      w(8);
      rd(`REG_STATUS, 32'h054, 32'h35f);
      trip <= 1'b0;
      warn <= 1'b0;
      w(8);
      rd(`REG_STATUS, 32'h244, 32'h35f);
      check_word("hs_on", 32'h0, {28'h0, hs_on});
      want_run <= 1'b0;
      w(8);
      rd(`REG_STATUS, 32'h300, 32'h35f);
      check_word("ls_on", 32'h0, {28'h0, ls_on});
      want_run <= 1'b1;
      w(60);
      rd(`REG_STATUS, 32'h340, 32'h35f);
      strap <= 1'b1;
      oc <= 4'h1;
      w(8);
      rd(`REG_CHAN, 32'h1, 32'hf);
      drive_ok(4'hc);
      check_word("hs_on0", 32'h0, {31'h0, hs_on[0]});
      oc <= 4'h0;
      strap <= 1'b0;
      want_run <= 1'b0;
      w(8);
      want_run <= 1'b1;
      w(60);
      rd(`REG_CHAN, 32'h0, 32'hf);
      test_done;
   end
endmodule // amp_fault_protection_supervisor_tb
`default_nettype wire
